// [inc/pagm_pkg.sv]
// Constants shared by the port A pin multiplexer
package pagm_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [15:0] PAGM_DIR_ADDR = 16'hFFD1;
  localparam logic [15:0] PAGM_DATA_ADDR = 16'hFFD3;

  // ****************************************
  // Widths and reset values
  // ****************************************
  localparam int PAGM_W = 8;
  localparam int PAGM_PIN7 = 7;
  localparam logic [7:0] PAGM_DIR_RST_IO = 8'h00;
  localparam logic [7:0] PAGM_DIR_RST_ADDR = 8'h80;
  localparam logic [7:0] PAGM_DATA_RST = 8'h00;
  localparam logic [7:0] PAGM_DIR_READ = 8'hFF;
  localparam logic [7:0] PAGM_UNMAPPED = 8'h00;

  // ****************************************
  // Operating modes with the address pin
  // ****************************************
  localparam logic [2:0] PAGM_MODE3 = 3'h3;
  localparam logic [2:0] PAGM_MODE4 = 3'h4;
  localparam logic [2:0] PAGM_MODE6 = 3'h6;

  // ****************************************
  // Timer channel 2 field positions
  // ****************************************
  localparam int PAGM_IO_HI = 2;
  localparam int PAGM_IO_MID = 1;
  localparam int PAGM_IO_LO = 0;

  // Function chosen for the top pin
  typedef enum logic [1:0] {
    PAGM_FN_ADDR,
    PAGM_FN_TIMER,
    PAGM_FN_PATTERN,
    PAGM_FN_PORT
  } pagm_fn_t;

endpackage

// [design/pagm_bit_cell.sv]
// One port bit: pin drive, enable and read-back selection
`timescale 1ns/1ns
`default_nettype none

module pagm_bit_cell (
  input wire logic dir_i,      // Direction bit, 1 drives the pin
  input wire logic out_i,      // Stored output data bit
  input wire logic pin_i,      // Sampled pin level
  input wire logic alt_i,      // Peripheral owns the pin
  input wire logic alt_d_i,    // Peripheral drive value
  input wire logic alt_oe_i,   // Peripheral drive enable
  output logic drive_o,        // Value for the pin
  output logic oe_o,           // Enable for the pin
  output logic rd_o            // Value seen by a port read
);

  // ****************************************
  // Drive and read-back
  // ****************************************
  // Plain I/O follows the direction bit; a peripheral overrides
  always_comb begin
    if (alt_i) begin
      drive_o = alt_d_i;
      oe_o = alt_oe_i;
    end else begin
      drive_o = out_i;
      oe_o = dir_i;
    end
    // output bit when direction is 1
    // pin level when direction is 0
    rd_o = dir_i ? out_i : pin_i;
  end

endmodule

`default_nettype wire

// [design/pagm_port.sv]
// Port A: registers, read path and top pin function select
`timescale 1ns/1ns
`default_nettype none

// Operation
// - Direction bit 1 drives, 0 inputs
// - Direction register reads back all ones
// - Modes 1,2,5,7 reset direction to zero
// - Modes 3,4,6 reset direction to 80
// - Modes 3,4,6 pin 7 fixed address output
// - Software standby keeps both registers
// - Driven pins hold state in software standby
// - Eight bit data register drives outputs
// - Read returns data bit when output
// - Read returns pin level when input
// - Reset clears data register in all modes
// - After reset all inputs except address
// - Pin 7 function follows timer settings
// - Field 001/01x timer, else setting two
// - Capture input from pin 7 when enabled
module pagm_port
  import pagm_pkg::*;
(
  input wire logic clk_i,                 // System clock
  input wire logic nrst_i,                // Sync reset, active low
  input wire logic hw_standby_i,          // Hardware standby
  input wire logic sw_standby_i,          // Software standby
  input wire logic [2:0] mode_i,          // Operating mode pins
  // Register port
  input wire logic [15:0] addr_i,         // Register address
  input wire logic [7:0] wdata_i,         // Write data
  input wire logic wr_i,                  // Write strobe
  input wire logic rd_i,                  // Read strobe
  output logic [7:0] rdata_o,             // Read data, next cycle
  // Timer channel 2 and pattern controls
  input wire logic timer_ch2_pulse_select_i,
  input wire logic [2:0] ch2_b_io_ctrl_i, // Pin 7 timer field
  input wire logic timer_ch2_b_pin_d_i,   // Timer compare output
  input wire logic pattern_out_enable_7_i,
  input wire logic pattern_out_7_i,       // Pattern data for pin 7
  input wire logic addr_bit_20_i,         // Address bit from bus
  output logic timer_ch2_b_pin_cap_o,     // Capture input to timer
  // Pins
  input wire logic [7:0] pin_i,           // Pin levels
  output logic [7:0] pin_o,               // Pin drive values
  output logic [7:0] pin_oe_o             // Pin drive enables
);

  // ****************************************
  // Mode decode
  // ****************************************
  // True in the modes where pin 7 carries the address
  function automatic logic addr_mode(input logic [2:0] m);
    addr_mode = (m == PAGM_MODE3) || (m == PAGM_MODE4) ||
                (m == PAGM_MODE6);
  endfunction

  // Timer field asks for compare output on pin 7
  function automatic logic timer_owns(input logic [2:0] f);
    timer_owns = !f[PAGM_IO_HI] && (f[PAGM_IO_MID] || f[PAGM_IO_LO]);
  endfunction

  logic addr_md;              // Pin 7 reserved for address
  logic load_rst;             // Reset or hardware standby
  logic wr_ok;                // Writes allowed this cycle
  logic dir_hit;              // Address hits direction register
  logic data_hit;             // Address hits data register

  assign addr_md = addr_mode(mode_i);
  assign load_rst = !nrst_i || hw_standby_i;
  // Registers frozen in software standby
  assign wr_ok = wr_i && !sw_standby_i;
  assign dir_hit = (addr_i == PAGM_DIR_ADDR);
  assign data_hit = (addr_i == PAGM_DATA_ADDR);

  // ****************************************
  // Direction and data registers
  // ****************************************
  logic [7:0] dir_reg;        // Direction, write only
  logic [7:0] dir_next;
  logic [7:0] out_reg;        // Output data
  logic [7:0] out_next;

  // Next state of both registers
  always_comb begin
    dir_next = dir_reg;
    out_next = out_reg;
    if (load_rst) begin
      dir_next = addr_md ? PAGM_DIR_RST_ADDR : PAGM_DIR_RST_IO;
      out_next = PAGM_DATA_RST;
    end else begin
      if (wr_ok && dir_hit) begin
        dir_next = wdata_i;
      end
      if (wr_ok && data_hit) begin
        out_next = wdata_i;
      end
      // bit 7 pinned high in address modes
      if (addr_md) begin
        dir_next[PAGM_PIN7] = 1'b1;
      end
    end
  end

  // Register stage, reset folded in above
  always_ff @(posedge clk_i) begin
    dir_reg <= dir_next;
    out_reg <= out_next;
  end

  // ****************************************
  // Pin 7 function select
  // ****************************************
  pagm_fn_t fn7;              // Current pin 7 function
  logic alt7;                 // Pin 7 owned by a peripheral
  logic alt7_d;               // Its drive value
  logic alt7_oe;              // Its drive enable

  // Address first, then timer, then pattern, then port
  always_comb begin
    if (addr_md) begin
      fn7 = PAGM_FN_ADDR;
    // field 001 or 01x picks timer
    end else if (timer_owns(ch2_b_io_ctrl_i)) begin
      fn7 = PAGM_FN_TIMER;
    end else if (dir_reg[PAGM_PIN7] && pattern_out_enable_7_i) begin
      fn7 = PAGM_FN_PATTERN;
    end else begin
      fn7 = PAGM_FN_PORT;
    end
  end

  // Drive seen by the bit cell for pin 7
  always_comb begin
    case (fn7)
      PAGM_FN_ADDR: begin
        alt7 = 1'b1;
        alt7_d = addr_bit_20_i;
        alt7_oe = 1'b1;
      end
      PAGM_FN_TIMER: begin
        alt7 = 1'b1;
        alt7_d = timer_ch2_b_pin_d_i;
        alt7_oe = 1'b1;
      end
      PAGM_FN_PATTERN: begin
        alt7 = 1'b1;
        alt7_d = pattern_out_7_i;
        alt7_oe = 1'b1;
      end
      PAGM_FN_PORT: begin
        alt7 = 1'b0;
        alt7_d = 1'b0;
        alt7_oe = 1'b0;
      end
      default: begin
        alt7 = 1'b0;
        alt7_d = 1'b0;
        alt7_oe = 1'b0;
      end
    endcase
  end

  // capture path regardless of pin use
  assign timer_ch2_b_pin_cap_o = ch2_b_io_ctrl_i[PAGM_IO_HI] &&
                                 !timer_ch2_pulse_select_i &&
                                 pin_i[PAGM_PIN7];

  // ****************************************
  // Per-bit cells
  // ****************************************
  logic [7:0] alt_v;          // Peripheral ownership per bit
  logic [7:0] alt_d_v;        // Peripheral data per bit
  logic [7:0] alt_oe_v;       // Peripheral enable per bit
  logic [7:0] drv_v;          // Cell drive values
  logic [7:0] oe_v;           // Cell drive enables
  logic [7:0] rd_v;           // Cell read-back values

  // Only pin 7 has a modelled peripheral; others are plain I/O
  assign alt_v = {alt7, 7'h00};
  assign alt_d_v = {alt7_d, 7'h00};
  assign alt_oe_v = {alt7_oe, 7'h00};

  genvar gi;
  generate
    for (gi = 0; gi < PAGM_W; gi++) begin : g_bit
      pagm_bit_cell u_cell (
        .dir_i(dir_reg[gi]),
        .out_i(out_reg[gi]),
        .pin_i(pin_i[gi]),
        .alt_i(alt_v[gi]),
        .alt_d_i(alt_d_v[gi]),
        .alt_oe_i(alt_oe_v[gi]),
        .drive_o(drv_v[gi]),
        .oe_o(oe_v[gi]),
        .rd_o(rd_v[gi])
      );
    end
  endgenerate

  // ****************************************
  // Pin output stage
  // ****************************************
  logic [7:0] pin_reg;        // Registered pin values
  logic [7:0] pin_next;
  logic [7:0] pin_oe_reg;     // Registered enables
  logic [7:0] pin_oe_next;

  // Freeze the pins in software standby so outputs hold
  always_comb begin
    pin_next = pin_reg;
    pin_oe_next = pin_oe_reg;
    if (!nrst_i) begin
      // Reset: no drive, reset values load one cycle later
      pin_next = 8'h00;
      pin_oe_next = 8'h00;
    end else if (!sw_standby_i) begin
      pin_next = drv_v;
      pin_oe_next = oe_v;
    end
  end

  // Output registers, one cycle behind the cells
  always_ff @(posedge clk_i) begin
    pin_reg <= pin_next;
    pin_oe_reg <= pin_oe_next;
  end

  assign pin_o = pin_reg;
  assign pin_oe_o = pin_oe_reg;

  // ****************************************
  // Read path
  // ****************************************
  logic [7:0] rdata_reg;      // Read data, one cycle after strobe
  logic [7:0] rdata_next;

  // Strobe cycle picks the value; it stands one cycle only
  always_comb begin
    rdata_next = 8'h00;
    if (!nrst_i) begin
      rdata_next = 8'h00;
    end else if (rd_i) begin
      if (dir_hit) begin
        rdata_next = PAGM_DIR_READ;
      end else if (data_hit) begin
        rdata_next = rd_v;
      end else begin
        rdata_next = PAGM_UNMAPPED;
      end
    end
  end

  // Read data register
  always_ff @(posedge clk_i) begin
    rdata_reg <= rdata_next;
  end

  assign rdata_o = rdata_reg;

endmodule

`default_nettype wire

// [dv/pagm_pin_model.sv]
// Far-side pin model: resolves the level seen on each port pin
`timescale 1ns/1ns
`default_nettype none
module pagm_pin_model (
  input wire logic [7:0] drv_i, // Port drive values
  input wire logic [7:0] oe_i,  // Port drive enables
  input wire logic [7:0] ext_i, // Outside drivers on undriven pins
  output logic [7:0] lvl_o      // Resolved pin level
);
  // Outside level changes in the software standby test, so stale port values cannot pass
  assign lvl_o = (oe_i & drv_i) | (~oe_i & ext_i);
endmodule
`default_nettype wire

// [dv/pagm_port_props.sv]
// Checker for port A pins and register reads
`timescale 1ns/1ns
`default_nettype none
module pagm_port_props
  import pagm_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic sw_standby_i,
  input wire logic [2:0] mode_i,
  input wire logic [15:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic timer_ch2_pulse_select_i,
  input wire logic [2:0] ch2_b_io_ctrl_i,
  input wire logic timer_ch2_b_pin_d_i,
  input wire logic pattern_out_enable_7_i,
  input wire logic pattern_out_7_i,
  input wire logic addr_bit_20_i,
  input wire logic timer_ch2_b_pin_cap_o,
  input wire logic [7:0] pin_i,
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe_o
);
  // ****************
  // Helpers
  // ****************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  logic amode; // Pin 7 carries the address
  assign amode = mode_i inside {PAGM_MODE3, PAGM_MODE4, PAGM_MODE6};
  // Reset edge followed by the release edge
  sequence s_release;
    !nrst_i ##1 nrst_i;
  endsequence
  AST_DIR_READ:
  assert property (rd_i && addr_i == PAGM_DIR_ADDR |=> rdata_o == 8'hFF)
    else $error("direction read not all ones");
  AST_RST_INPUTS:
  assert property (disable iff (1'b0) s_release |=> pin_oe_o[6:0] == 7'h00)
    else $error("pins driven after reset");
  AST_ADDR_PIN:
  assert property (amode && $past(nrst_i) && !$past(sw_standby_i)
    |-> pin_oe_o[7] && pin_o[7] == $past(addr_bit_20_i))
    else $error("pin 7 not carrying the address");
  AST_CAPTURE:
  assert property (timer_ch2_b_pin_cap_o == (pin_i[7]
    & ch2_b_io_ctrl_i[2] & ~timer_ch2_pulse_select_i))
    else $error("capture input wrong");
  AST_TIMER_FN:
  assert property (!amode && $past(nrst_i) && !$past(sw_standby_i)
    && $past(ch2_b_io_ctrl_i) inside {3'h1, 3'h2, 3'h3}
    |-> pin_oe_o[7] && pin_o[7] == $past(timer_ch2_b_pin_d_i))
    else $error("pin 7 not a timer output");
  AST_PATTERN_FN:
  assert property (!amode && $past(nrst_i) && !$past(sw_standby_i)
    && !($past(ch2_b_io_ctrl_i) inside {3'h1, 3'h2, 3'h3})
    && $past(pattern_out_enable_7_i) && pin_oe_o[7]
    |-> pin_o[7] == $past(pattern_out_7_i))
    else $error("pin 7 not a pattern output");
  AST_FREEZE:
  assert property (sw_standby_i |=> $stable(pin_o) && $stable(pin_oe_o))
    else $error("pins moved in software standby");
  AST_RD_INPUT:
  assert property (rd_i && addr_i == PAGM_DATA_ADDR && !$past(wr_i)
    && !$past(sw_standby_i) |=> ((rdata_o ^ $past(pin_i))
    & ~$past(pin_oe_o) & 8'h7F) == 8'h00)
    else $error("input bit not read from pin");
endmodule
bind pagm_port pagm_port_props u_props (.clk_i(clk_i), .nrst_i(nrst_i),
  .sw_standby_i(sw_standby_i), .mode_i(mode_i), .addr_i(addr_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .timer_ch2_pulse_select_i(timer_ch2_pulse_select_i),
  .ch2_b_io_ctrl_i(ch2_b_io_ctrl_i),
  .timer_ch2_b_pin_d_i(timer_ch2_b_pin_d_i),
  .pattern_out_enable_7_i(pattern_out_enable_7_i),
  .pattern_out_7_i(pattern_out_7_i), .addr_bit_20_i(addr_bit_20_i),
  .timer_ch2_b_pin_cap_o(timer_ch2_b_pin_cap_o), .pin_i(pin_i),
  .pin_o(pin_o), .pin_oe_o(pin_oe_o));
`default_nettype wire

// [dv/testbench.sv]
// Self-checking testbench for the port A block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import pagm_pkg::*;
  int err_count = 0;
  int check_count = 0;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic hw = 1'b0;
  logic sw = 1'b0;
  logic [2:0] mode = 3'h1;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic pwm = 1'b0;
  logic [2:0] io = 3'h0;
  logic tmr = 1'b0;
  logic pen = 1'b1;
  logic pat = 1'b1;
  logic a20 = 1'b0;
  logic [7:0] ext = 8'hA5; // Outside level on undriven pins
  logic [7:0] rdata, lvl, drv, oe;
  logic cap;
  pagm_port u_dut (.clk_i(clk), .nrst_i(nrst), .hw_standby_i(hw),
    .sw_standby_i(sw), .mode_i(mode), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .timer_ch2_pulse_select_i(pwm),
    .ch2_b_io_ctrl_i(io), .timer_ch2_b_pin_d_i(tmr),
    .pattern_out_enable_7_i(pen), .pattern_out_7_i(pat),
    .addr_bit_20_i(a20), .timer_ch2_b_pin_cap_o(cap), .pin_i(lvl),
    .pin_o(drv), .pin_oe_o(oe));
  pagm_pin_model u_pins (.drv_i(drv), .oe_i(oe), .ext_i(ext), .lvl_o(lvl));
  initial forever #5 clk = ~clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Data stand only in the cycle after the strobe
  task automatic rreg(input logic [15:0] a, output logic [7:0] q);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 q = rdata;
  endtask
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask
  // Mode is only changed under reset, where it is sampled
  task automatic reset(input logic [2:0] m);
    @(posedge clk);
    nrst <= 1'b0;
    mode <= m;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    #100000;
    err_count++;
    results;
  end
  initial begin
    logic [7:0] q;
    reset(3'h1);
    rreg(PAGM_DIR_ADDR, q);
    chk(q, PAGM_DIR_READ);
    rreg(PAGM_DATA_ADDR, q);
    chk(q, 8'hA5);
    rreg(16'h0000, q);
    chk(q, PAGM_UNMAPPED);
    wreg(PAGM_DIR_ADDR, 8'h0F);
    wreg(PAGM_DATA_ADDR, 8'h5A);
    rreg(PAGM_DATA_ADDR, q);
    chk(q, 8'hAA);
    settle;
    chk(oe, 8'h0F);
    chk(drv & oe, 8'h0A);
    $display("test plain io done");
    @(posedge clk);
    sw <= 1'b1;
    wreg(PAGM_DIR_ADDR, 8'hF0);
    wreg(PAGM_DATA_ADDR, 8'hFF);
    ext <= 8'h3C;
    settle;
    chk(oe, 8'h0F);
    @(posedge clk);
    sw <= 1'b0;
    rreg(PAGM_DATA_ADDR, q);
    chk(q, 8'h3A);
    $display("test software standby done");
    @(posedge clk);
    hw <= 1'b1;
    @(posedge clk);
    hw <= 1'b0;
    rreg(PAGM_DATA_ADDR, q);
    chk(q, 8'h3C);
    wreg(PAGM_DIR_ADDR, 8'hFF);
    rreg(PAGM_DATA_ADDR, q);
    chk(q, PAGM_DATA_RST);
    $display("test hardware standby done");
    // Timer output low, pattern high: each setting shows apart
    for (int f = 0; f < 8; f++) begin
      @(posedge clk);
      io <= f[2:0];
      settle;
      chk({7'h00, drv[7]}, (f inside {1, 2, 3}) ? 8'h00 : 8'h01);
      chk({7'h00, cap}, (f > 3) ? 8'h01 : 8'h00);
    end
    // Timer high, pattern low: a tied-off timer drive cannot pass
    @(posedge clk);
    io <= 3'h2;
    tmr <= 1'b1;
    pat <= 1'b0;
    settle;
    chk({6'h00, oe[7], drv[7]}, 8'h03);
    // Data bit 7 high so the pin is high and the gating shows
    wreg(PAGM_DATA_ADDR, 8'h80);
    @(posedge clk);
    pwm <= 1'b1;
    pen <= 1'b0;
    io <= 3'h4;
    settle;
    chk({7'h00, cap}, 8'h00);
    chk({6'h00, oe[7], drv[7]}, 8'h03);
    $display("test pin 7 functions done");
    reset(3'h3);
    settle;
    chk(oe, PAGM_DIR_RST_ADDR);
    wreg(PAGM_DIR_ADDR, 8'h01);
    @(posedge clk);
    a20 <= 1'b1;
    settle;
    chk(oe, 8'h81);
    chk({7'h00, drv[7]}, 8'h01);
    // Other address modes, and hardware standby in one of them
    reset(3'h4);
    settle;
    chk(oe, PAGM_DIR_RST_ADDR);
    reset(3'h6);
    wreg(PAGM_DIR_ADDR, 8'h7F);
    settle;
    chk(oe, 8'hFF);
    @(posedge clk);
    hw <= 1'b1;
    @(posedge clk);
    hw <= 1'b0;
    settle;
    chk(oe, PAGM_DIR_RST_ADDR);
    $display("test address mode done");
    results;
  end
endmodule
`default_nettype wire
